// [shared/fcl_pkg.sv]
// fcl_pkg: register map, field positions and counts of the fir coefficient loader
// assumes an 8-bit register port driven by a serial-control front end on mclk
package fcl_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] FCL_OFS_CTRL = 8'h25; // filter_load_control
    localparam logic [7:0] FCL_OFS_S1_B0 = 8'h26; // stage1_coeff_byte0, bits 7:0
    localparam logic [7:0] FCL_OFS_S1_B1 = 8'h27; // stage1_coeff_byte1, bits 15:8
    localparam logic [7:0] FCL_OFS_S1_B2 = 8'h28; // stage1_coeff_byte2, bits 23:16
    localparam logic [7:0] FCL_OFS_S1_B3 = 8'h29; // stage1_coeff_byte3, bits 31:24
    localparam logic [7:0] FCL_OFS_S2_B0 = 8'h2a; // stage2_coeff_byte0
    localparam logic [7:0] FCL_OFS_S2_B1 = 8'h2b; // stage2_coeff_byte1
    localparam logic [7:0] FCL_OFS_S2_B2 = 8'h2c; // stage2_coeff_byte2
    localparam logic [7:0] FCL_OFS_S2_B3 = 8'h2d; // stage2_coeff_byte3
    // control register fields
    localparam int FCL_BIT_S2_LOAD = 0; // stage 2 load enable
    localparam int FCL_BIT_S2_CUSTOM = 1; // stage 2 uses loaded coefficients
    localparam int FCL_BIT_S1_LOAD = 4; // stage 1 load enable
    localparam int FCL_BIT_S1_CUSTOM = 5; // stage 1 uses loaded coefficients
    localparam logic [7:0] FCL_CTRL_RESET = 8'h00; // value after reset
    // geometry
    localparam int FCL_CHANNELS = 8;
    localparam logic [2:0] FCL_LAST_CH = 3'h7; // channel eight, counted from zero
    localparam logic [5:0] FCL_S1_LAST_IDX = 6'h3f; // 64 coefficients per channel
    localparam logic [5:0] FCL_S2_LAST_IDX = 6'h0f; // 16 coefficients per channel
    localparam int FCL_S1_BYTES = 2048;
    localparam int FCL_S2_BYTES = 512;
    // stage encoding on the commit stream
    typedef enum logic [0:0] {
        FCL_STAGE1 = 1'b0,
        FCL_STAGE2 = 1'b1
    } fcl_stage_t;
endpackage : fcl_pkg

// [hdl/fcl_loader.sv]
// fcl_loader: control register, byte assembly and commit sequencing for the two fir stages
// assumes a register port on mclk (one-cycle write/read strobes) and async status levels for
// the audio data clock and converter lock; filter arithmetic and coefficient storage sit outside
`timescale 1ns/1ps
`default_nettype none

// Contract
// - two stages, each built-in or loaded, per-channel
// - control bits 5 and 1 select coefficient source
// - stage one bytes msb first, 0x29 down to 0x26
// - channels interleaved within each coefficient index
// - stage one: 64 coefficients, 2048 bytes
// - stage two bytes msb first, 0x2d down to 0x2a
// - stage two: 16 coefficients, 512 bytes
module fcl_loader (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic reg_rd, // one-cycle read strobe
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata, // valid the cycle after reg_rd
    input wire logic data_clk_active, // async: audio data clock is running
    input wire logic dac_locked, // async: converter reports lock
    output logic s1_custom, // stage 1 uses loaded coefficients
    output logic s2_custom, // stage 2 uses loaded coefficients
    output logic s1_loading, // stage 1 load enable bit
    output logic s2_loading,
    output logic s1_loaded, // stage 1 full load finalised
    output logic s2_loaded,
    output logic coef_valid, // one-cycle commit pulse
    output logic coef_stage, // 0 stage 1, 1 stage 2
    output logic [2:0] coef_channel,
    output logic [5:0] coef_index,
    output logic [31:0] coef_data
);

    // address match used by every write decode below
    function automatic logic fcl_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
        fcl_hit = wr && (a == ofs);
    endfunction : fcl_hit

    // synchroniser for the two async status levels; stage one is read only by stage two
    logic clk_meta_reg, clk_ok_reg, lock_meta_reg, lock_ok_reg;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clk_meta_reg <= 1'b0;
            clk_ok_reg <= 1'b0;
            lock_meta_reg <= 1'b0;
            lock_ok_reg <= 1'b0;
        end else begin
            clk_meta_reg <= data_clk_active;
            clk_ok_reg <= clk_meta_reg;
            lock_meta_reg <= dac_locked;
            lock_ok_reg <= lock_meta_reg;
        end
    end

    logic load_ok; // loading is only meaningful while audio path is alive
    assign load_ok = clk_ok_reg && lock_ok_reg;

    // register state
    logic [7:0] ctrl_reg, ctrl_next; // filter_load_control
    logic [23:0] s1_hold_reg, s1_hold_next; // stage 1 upper three bytes
    logic [23:0] s2_hold_reg, s2_hold_next;
    logic [2:0] s1_ch_reg, s1_ch_next; // next channel to commit
    logic [5:0] s1_idx_reg, s1_idx_next; // next coefficient index
    logic [2:0] s2_ch_reg, s2_ch_next;
    logic [3:0] s2_idx_reg, s2_idx_next;
    logic s1_full_reg, s1_full_next; // all 2048 bytes taken
    logic s2_full_reg, s2_full_next; // all 512 bytes taken
    logic s1_loaded_reg, s1_loaded_next;
    logic s2_loaded_reg, s2_loaded_next;
    logic cv_reg, cv_next; // commit pulse
    logic cs_reg, cs_next;
    logic [2:0] cch_reg, cch_next;
    logic [5:0] cidx_reg, cidx_next;
    logic [31:0] cdata_reg, cdata_next;
    logic [7:0] rdata_reg, rdata_next;

    // write decodes
    logic wr_ctrl, wr_s1_b0, wr_s2_b0;
    assign wr_ctrl = fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_CTRL);
    assign wr_s1_b0 = fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S1_B0);
    assign wr_s2_b0 = fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S2_B0);

    logic s1_en, s2_en, s1_rise, s2_rise, s1_fall, s2_fall;
    assign s1_en = ctrl_reg[fcl_pkg::FCL_BIT_S1_LOAD];
    assign s2_en = ctrl_reg[fcl_pkg::FCL_BIT_S2_LOAD];
    assign s1_rise = wr_ctrl && !s1_en && reg_wdata[fcl_pkg::FCL_BIT_S1_LOAD];
    assign s2_rise = wr_ctrl && !s2_en && reg_wdata[fcl_pkg::FCL_BIT_S2_LOAD];
    assign s1_fall = wr_ctrl && s1_en && !reg_wdata[fcl_pkg::FCL_BIT_S1_LOAD];
    assign s2_fall = wr_ctrl && s2_en && !reg_wdata[fcl_pkg::FCL_BIT_S2_LOAD];

    // a commit happens on the low byte while enabled, healthy and not yet full;
    // the trailing zero write after the last coefficient lands on a full stage and is dropped
    logic s1_commit, s2_commit;
    assign s1_commit = wr_s1_b0 && s1_en && load_ok && !s1_full_reg;
    assign s2_commit = wr_s2_b0 && s2_en && load_ok && !s2_full_reg;

    // next-state logic for registers, counters and the commit stream
    always_comb begin
        ctrl_next = ctrl_reg;
        s1_hold_next = s1_hold_reg;
        s2_hold_next = s2_hold_reg;
        s1_ch_next = s1_ch_reg;
        s1_idx_next = s1_idx_reg;
        s2_ch_next = s2_ch_reg;
        s2_idx_next = s2_idx_reg;
        s1_full_next = s1_full_reg;
        s2_full_next = s2_full_reg;
        s1_loaded_next = s1_loaded_reg;
        s2_loaded_next = s2_loaded_reg;
        cv_next = 1'b0;
        cs_next = cs_reg;
        cch_next = cch_reg;
        cidx_next = cidx_reg;
        cdata_next = cdata_reg;
        rdata_next = rdata_reg;
        // control register: source select bits and load enables, per stage independently
        if (wr_ctrl) begin
            ctrl_next = reg_wdata;
        end
        // upper bytes just park until the low byte arrives, msb first order
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S1_B3)) begin
            s1_hold_next[23:16] = reg_wdata;
        end
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S1_B2)) begin
            s1_hold_next[15:8] = reg_wdata;
        end
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S1_B1)) begin
            s1_hold_next[7:0] = reg_wdata;
        end
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S2_B3)) begin
            s2_hold_next[23:16] = reg_wdata;
        end
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S2_B2)) begin
            s2_hold_next[15:8] = reg_wdata;
        end
        if (fcl_hit(reg_wr, reg_addr, fcl_pkg::FCL_OFS_S2_B1)) begin
            s2_hold_next[7:0] = reg_wdata;
        end
        // stage 1 commit: channel runs fastest, index after eight channels
        if (s1_commit) begin
            cv_next = 1'b1;
            cs_next = fcl_pkg::FCL_STAGE1;
            cch_next = s1_ch_reg;
            cidx_next = s1_idx_reg;
            cdata_next = {s1_hold_reg, reg_wdata};
            s1_ch_next = s1_ch_reg + 3'h1;
            if (s1_ch_reg == fcl_pkg::FCL_LAST_CH) begin
                s1_idx_next = s1_idx_reg + 6'h01;
                if (s1_idx_reg == fcl_pkg::FCL_S1_LAST_IDX) begin
                    s1_full_next = 1'b1;
                end
            end
        end else if (s2_commit) begin
            // both stages never commit together: they share the same one-byte write port
            cv_next = 1'b1;
            cs_next = fcl_pkg::FCL_STAGE2;
            cch_next = s2_ch_reg;
            cidx_next = {2'b00, s2_idx_reg};
            cdata_next = {s2_hold_reg, reg_wdata};
            s2_ch_next = s2_ch_reg + 3'h1;
            if (s2_ch_reg == fcl_pkg::FCL_LAST_CH) begin
                s2_idx_next = s2_idx_reg + 4'h1;
                if ({2'b00, s2_idx_reg} == fcl_pkg::FCL_S2_LAST_IDX) begin
                    s2_full_next = 1'b1;
                end
            end
        end
        // enabling a stage restarts it at channel one, coefficient one
        if (s1_rise) begin
            s1_ch_next = 3'h0;
            s1_idx_next = 6'h00;
            s1_full_next = 1'b0;
            s1_loaded_next = 1'b0;
        end
        if (s2_rise) begin
            s2_ch_next = 3'h0;
            s2_idx_next = 4'h0;
            s2_full_next = 1'b0;
            s2_loaded_next = 1'b0;
        end
        // finalise only counts when every coefficient came in; a short load stays unloaded
        if (s1_fall) begin
            s1_loaded_next = s1_full_reg;
        end
        if (s2_fall) begin
            s2_loaded_next = s2_full_reg;
        end
        // read path: control reads back, byte ports are write-only and read zero
        if (reg_rd) begin
            rdata_next = (reg_addr == fcl_pkg::FCL_OFS_CTRL) ? ctrl_reg : 8'h00;
        end
    end

    // state registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= fcl_pkg::FCL_CTRL_RESET;
            s1_hold_reg <= 24'h000000;
            s2_hold_reg <= 24'h000000;
            s1_ch_reg <= 3'h0;
            s1_idx_reg <= 6'h00;
            s2_ch_reg <= 3'h0;
            s2_idx_reg <= 4'h0;
            s1_full_reg <= 1'b0;
            s2_full_reg <= 1'b0;
            s1_loaded_reg <= 1'b0;
            s2_loaded_reg <= 1'b0;
            cv_reg <= 1'b0;
            cs_reg <= 1'b0;
            cch_reg <= 3'h0;
            cidx_reg <= 6'h00;
            cdata_reg <= 32'h00000000;
            rdata_reg <= 8'h00;
        end else begin
            ctrl_reg <= ctrl_next;
            s1_hold_reg <= s1_hold_next;
            s2_hold_reg <= s2_hold_next;
            s1_ch_reg <= s1_ch_next;
            s1_idx_reg <= s1_idx_next;
            s2_ch_reg <= s2_ch_next;
            s2_idx_reg <= s2_idx_next;
            s1_full_reg <= s1_full_next;
            s2_full_reg <= s2_full_next;
            s1_loaded_reg <= s1_loaded_next;
            s2_loaded_reg <= s2_loaded_next;
            cv_reg <= cv_next;
            cs_reg <= cs_next;
            cch_reg <= cch_next;
            cidx_reg <= cidx_next;
            cdata_reg <= cdata_next;
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_reg;
    assign s1_custom = ctrl_reg[fcl_pkg::FCL_BIT_S1_CUSTOM];
    assign s2_custom = ctrl_reg[fcl_pkg::FCL_BIT_S2_CUSTOM];
    assign s1_loading = s1_en;
    assign s2_loading = s2_en;
    assign s1_loaded = s1_loaded_reg;
    assign s2_loaded = s2_loaded_reg;
    assign coef_valid = cv_reg;
    assign coef_stage = cs_reg;
    assign coef_channel = cch_reg;
    assign coef_index = cidx_reg;
    assign coef_data = cdata_reg;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_commit_low_byte: assert property (s1_commit |=> coef_valid && coef_stage == 1'b0
        && coef_data[7:0] == $past(reg_wdata)) else $error("stage 1 commit lost");
    a_commit_msb_order: assert property (s1_commit |=> coef_data[31:8] == $past(s1_hold_reg))
        else $error("stage 1 upper bytes wrong");
    a_s2_msb_order: assert property (s2_commit |=> coef_data[31:8] == $past(s2_hold_reg)
        && coef_stage == 1'b1) else $error("stage 2 upper bytes wrong");
    a_gate_on_health: assert property (!load_ok |=> !coef_valid)
        else $error("commit without clock and lock");
    a_channel_interleave: assert property (s1_commit && s1_ch_reg != fcl_pkg::FCL_LAST_CH
        |=> s1_ch_reg == $past(s1_ch_reg) + 3'h1 && s1_idx_reg == $past(s1_idx_reg))
        else $error("channel did not advance first");
    a_s1_full_point: assert property (s1_commit && s1_ch_reg == fcl_pkg::FCL_LAST_CH
        && s1_idx_reg == fcl_pkg::FCL_S1_LAST_IDX |=> s1_full_reg)
        else $error("stage 1 full not at 64th index");
    a_s2_full_point: assert property (s2_commit && s2_ch_reg == fcl_pkg::FCL_LAST_CH
        && s2_idx_reg == 4'hf |=> s2_full_reg ##1 s2_full_reg || s2_rise)
        else $error("stage 2 full not at 16th index");
    a_enable_restart: assert property (s1_rise |=> s1_ch_reg == 3'h0 && s1_idx_reg == 6'h00
        && !s1_full_reg) else $error("stage 1 counters not reset");
    a_s2_restart: assert property (s2_rise |=> s2_ch_reg == 3'h0 && s2_idx_reg == 4'h0)
        else $error("stage 2 counters not reset");
    a_trailing_zero: assert property (s1_full_reg && wr_s1_b0 |=> !coef_valid)
        else $error("trailing zero committed");
    a_finalise_s2: assert property (s2_fall && s2_full_reg |=> s2_loaded ##1 s2_loaded || s2_rise)
        else $error("stage 2 not finalised");
    a_source_select: assert property (wr_ctrl |=> s1_custom == $past(reg_wdata[5])
        && s2_custom == $past(reg_wdata[1])) else $error("source select not stored");

    c_s1_commit: cover property (s1_commit ##1 coef_valid);
    c_s1_full: cover property (s1_full_reg && s1_fall);
    c_s2_loaded: cover property (s2_fall && s2_full_reg ##1 s2_loaded);
    c_blocked: cover property (wr_s1_b0 && s1_en && !load_ok);

endmodule : fcl_loader

`default_nettype wire

// [sim/fcl_host_model.sv]
// fcl_host_model: behavioural serial-control host that writes and reads the loader's register port
// assumes its tasks are called just after a rising edge of mclk, one caller at a time
`timescale 1ns/1ps
`default_nettype none
module fcl_host_model (
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // port idle at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // coefficient pattern: bytes differ with stage, channel and index
    function automatic logic [31:0] word(input logic s, input logic [2:0] ch, input logic [5:0] idx);
        word = {s ? 8'h2b : 8'h1a, 5'h00, ch, 2'h0, idx, 2'h3, ~idx};
    endfunction : word
    // one byte write per cycle; held until the next rising edge samples it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_wr = 1'b1;
        reg_rd = 1'b0;
        reg_addr = a;
        reg_wdata = d;
    endtask : wr
    // release the port; data is inverted each cycle so a stale byte never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
            reg_wr = 1'b0;
            reg_rd = 1'b0;
            reg_wdata = ~reg_wdata;
        end
    endtask : idle
    // read strobe for one cycle, data taken once the sampling edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        reg_addr = a;
        idle(1);
        d = reg_rdata;
    endtask : rd
    // whole load of one stage, finished before returning, gap idles a slow host
    task automatic load(input logic s, input int nidx, input int gap);
        logic [7:0] base;
        logic [31:0] w;
        base = s ? fcl_pkg::FCL_OFS_S2_B0 : fcl_pkg::FCL_OFS_S1_B0;
        wr(fcl_pkg::FCL_OFS_CTRL, s ? 8'h01 : 8'h10);
        for (int i = 0; i < nidx; i++) begin
            for (int c = 0; c < fcl_pkg::FCL_CHANNELS; c++) begin
                w = word(s, 3'(c), 6'(i));
                for (int b = 3; b >= 0; b--) begin
                    wr(base + 8'(b), w[8*b +: 8]);
                end
                if (gap > 0) begin
                    idle(gap);
                end
            end
        end
        // an aborted short load skips the trailing zero: on a stage that is not full it would commit
        if (nidx == int'(s ? fcl_pkg::FCL_S2_LAST_IDX : fcl_pkg::FCL_S1_LAST_IDX) + 1) begin
            wr(base, 8'h00);
        end
        wr(fcl_pkg::FCL_OFS_CTRL, 8'h00);
        idle(1);
    endtask : load
endmodule : fcl_host_model
`default_nettype wire

// [sim/test_fcl_loader.sv]
// test_fcl_loader: self-checking bench for the coefficient loader driven by the host model
// assumes the loader commits one cycle after a low-byte write and syncs status in two edges
`timescale 1ns/1ps
`default_nettype none
module test_fcl_loader;
    logic mclk, rst, reg_wr, reg_rd, data_clk_active, dac_locked;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic s1_custom, s2_custom, s1_loading, s2_loading, s1_loaded, s2_loaded;
    logic coef_valid, coef_stage;
    logic [2:0] coef_channel;
    logic [5:0] coef_index;
    logic [31:0] coef_data;
    logic [1:0] health; // {audio data clock running, converter locked}
    assign {data_clk_active, dac_locked} = health;
    int fails = 0;
    int checks_done = 0;
    int commits = 0; // commits seen since the last expect_load
    logic exp_stage;
    logic [2:0] exp_ch;
    logic [5:0] exp_idx;
    fcl_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    fcl_loader uut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .data_clk_active(data_clk_active),
        .dac_locked(dac_locked), .s1_custom(s1_custom), .s2_custom(s2_custom), .s1_loading(s1_loading),
        .s2_loading(s2_loading), .s1_loaded(s1_loaded), .s2_loaded(s2_loaded), .coef_valid(coef_valid),
        .coef_stage(coef_stage), .coef_channel(coef_channel), .coef_index(coef_index), .coef_data(coef_data));
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // single compare for every kind of value, four-state exact
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // commit monitor on the falling edge, where the registered pulse has settled
    always @(negedge mclk) begin
        if (coef_valid === 1'b1) begin
            commits++;
            check("coef_data", host.word(exp_stage, exp_ch, exp_idx), coef_data);
            check("coef_place", {exp_stage, exp_ch, exp_idx}, {coef_stage, coef_channel, coef_index});
            if (exp_ch == fcl_pkg::FCL_LAST_CH) begin
                exp_idx++;
            end
            exp_ch++;
        end
    end
    // every load is expected to restart at channel one, index one
    task automatic expect_load(input logic s);
        exp_stage = s;
        exp_ch = 3'h0;
        exp_idx = 6'h00;
        commits = 0;
    endtask : expect_load
    task automatic t_reset();
        logic [7:0] d;
        check("idle_outputs", 32'h0, 32'({s1_custom, s2_custom, s1_loading, s2_loading, s1_loaded, s2_loaded}));
        host.rd(fcl_pkg::FCL_OFS_CTRL, d);
        check("ctrl_reset", 32'(fcl_pkg::FCL_CTRL_RESET), 32'(d));
    endtask : t_reset
    // no commits without data clock or lock; a short load never reads as loaded
    task automatic t_refused();
        for (int k = 0; k < 3; k++) begin
            health = 2'(k);
            host.idle(4);
            expect_load(1'b0);
            host.load(1'b0, 1, 0);
            check("refused_commits", 32'h0, 32'(commits));
        end
        health = 2'h3;
        host.idle(4);
        expect_load(1'b0);
        host.load(1'b0, 1, 2);
        host.idle(2);
        check("short_commits", 32'd8, 32'(commits));
        check("short_loaded", 32'h0, 32'(s1_loaded));
    endtask : t_refused
    // full load of one stage; counters must restart after the earlier short load
    task automatic t_full(input logic s, input int nidx, input int gap, input int nbytes);
        expect_load(s);
        host.load(s, nidx, gap);
        host.idle(2);
        check("commit_count", 32'(nbytes / 4), 32'(commits));
        check("loaded_flags", {31'h0, 1'b1}, 32'({s1_loading, s2_loading, s ? s2_loaded : s1_loaded}));
    endtask : t_full
    // source select bits, read-back, unmapped and write-only reads
    task automatic t_select();
        logic [7:0] d;
        logic [7:0] v;
        for (int k = 0; k < 4; k++) begin
            v = {2'h0, k[1], 3'h0, k[0], 1'h0};
            host.wr(fcl_pkg::FCL_OFS_CTRL, v);
            host.idle(2);
            check("custom_sel", 32'({v[5], v[1]}), 32'({s1_custom, s2_custom}));
            host.rd(fcl_pkg::FCL_OFS_CTRL, d);
            check("ctrl_readback", 32'(v), 32'(d));
        end
        host.rd(8'h40, d);
        check("unmapped_read", 32'h0, 32'(d));
        host.rd(fcl_pkg::FCL_OFS_S1_B3, d);
        check("port_read", 32'h0, 32'(d));
    endtask : t_select
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // about 2900 cycles expected; nearly seven times that is a hang
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        wrap_up();
    end
    // main sequence; stage two only after stage one has been finalised
    initial begin
        rst = 1'b1;
        health = 2'h3;
        repeat (4) @(posedge mclk);
        #1;
        rst = 1'b0;
        host.idle(3);
        t_reset();
        t_refused();
        t_full(1'b0, 64, 0, fcl_pkg::FCL_S1_BYTES);
        t_full(1'b1, 16, 1, fcl_pkg::FCL_S2_BYTES);
        check("stage1_kept", 32'h1, 32'(s1_loaded));
        t_select();
        wrap_up();
    end
endmodule : test_fcl_loader
`default_nettype wire
